// File: bench/fsr_array_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// array engine
// ----
module fsr_array_model import fsr_pkg::*; (
	input wire logic sys_clk,
	input wire logic [1:0] op_kind,
	input wire logic fail_req,
	output var fsr_done_t array_result
);
	logic [2:0] cnt_r;
	// one done pulse per program or erase, late so busy is seen first
	always_ff @(posedge sys_clk) begin
		array_result <= '0;
		if (op_kind != 2'd1 && op_kind != 2'd2) begin
			cnt_r <= 3'h0;
		end else if (cnt_r != 3'h7) begin
			cnt_r <= cnt_r + 3'h1;
			if (cnt_r == 3'h5)
				array_result <= '{done: 1'b1, fail: fail_req};
		end
	end
endmodule : fsr_array_model
`default_nettype wire

// File: bench/fsr_status_one_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// port checks
// ----
module fsr_status_one_asserts import fsr_pkg::*; #(
	parameter int OP_CYCLES = 20
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire fsr_done_t array_result,
	input wire logic busy_flag,
	input wire logic [1:0] op_kind,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int REG_MAX = OP_CYCLES + 8;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	// answers stand until taken, one write at a time
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped");
	one_write_a: assert property (clk_en && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answered twice");
	// busy follows the operation in flight
	op_busy_a: assert property (op_kind != 2'd0 |-> busy_flag)
		else $error("op without busy");
	fail_hold_a: assert property (array_result.done && array_result.fail && op_kind != 2'd0
		|=> busy_flag [*3]) else $error("busy left after fail");
	done_ok_a: assert property (clk_en && array_result.done && !array_result.fail && op_kind != 2'd0
		|-> ##[1:3] !busy_flag) else $error("busy stuck");
	reg_time_a: assert property ($rose(op_kind == 2'd3)
		|-> busy_flag [*3] ##[1:REG_MAX] !busy_flag) else $error("register write timing");
	reset_clear_a: assert property ($rose(nrst)
		|-> !busy_flag && op_kind == 2'd0 && !s_axi_bvalid && !s_axi_rvalid) else $error("reset state");
endmodule : fsr_status_one_asserts
bind fsr_status_one fsr_status_one_asserts #(.OP_CYCLES(OP_CYCLES)) fsr_status_one_asserts_inst (.sys_clk, .nrst,
	.clk_en, .array_result, .busy_flag, .op_kind, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
	.s_axi_rready);
`default_nettype wire

// File: bench/test_flash_status_register_one.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsr_cfg.svh"
module test_flash_status_register_one import fsr_pkg::*;;
	localparam logic [11:0] VO = `FSR_ADDR_VOL;
	localparam logic [11:0] CM = `FSR_ADDR_CMD;
	localparam logic [1:0] OK = `FSR_AXI_OKAY;
	logic sys_clk, nrst, wp_n, fail_req, busy_flag;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] op_kind, s_axi_bresp, s_axi_rresp;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	fsr_done_t array_result;
	int err_total = 0;
	int n_checks = 0;
	// short register-write time keeps the run brief
	fsr_status_one #(.OP_CYCLES(4)) fsr_status_one_inst (.sys_clk, .nrst, .clk_en(1'b1), .write_protect_n(wp_n),
		.array_result, .busy_flag, .op_kind, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	fsr_array_model fsr_array_model_inst (.sys_clk, .op_kind, .fail_req, .array_result);
	// ----
	// helpers
	// ----
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic stall;
		err_total++;
		conclude();
	endtask : stall
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t seen %h expected %h", $time, got, exp);
		end
	endtask : check
	// request and bready stand until taken; the leading edge keeps calls from overlapping
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'b0;
		if (n == 64)
			stall();
		check({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : axi_wr
	task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		s_axi_rready <= 1'b0;
		if (n == 64)
			stall();
		check(s_axi_rdata, ed);
		check({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : axi_rd
	task automatic cmd(input logic [7:0] c);
		axi_wr(CM, {24'h0, c}, OK);
	endtask : cmd
	task automatic wait_idle;
		int n;
		for (n = 0; n < 99 && busy_flag !== 1'b0; n++)
			@(posedge sys_clk);
		if (n == 99)
			stall();
	endtask : wait_idle
	task automatic t_regwr(input logic [7:0] v, input logic [31:0] e);
		cmd(`FSR_CMD_WREN);
		axi_wr(CM, {16'h0, v, `FSR_CMD_WRVOL}, OK);
		wait_idle();
		axi_rd(VO, e, OK);
	endtask : t_regwr
	// ----
	// scenarios
	// ----
	task automatic t_wel;
		axi_rd(`FSR_ADDR_NV, 32'h0, OK);
		axi_rd(VO, 32'h0, OK);
		cmd(`FSR_CMD_WREN);
		axi_rd(VO, 32'h2, OK);
		cmd(`FSR_CMD_WRDIS);
		axi_rd(VO, 32'h0, OK);
		cmd(`FSR_CMD_WREN_VOL);
		axi_rd(VO, 32'h2, OK);
		cmd(`FSR_CMD_WRDIS);
		axi_wr(`FSR_ADDR_OP, 32'h0, OK);
		repeat (4) @(posedge sys_clk);
		check({31'h0, busy_flag}, 32'h0);
	endtask : t_wel
	// good program, failing program and erase, then program into the top 1/64
	task automatic t_ops;
		int k;
		int n;
		t_regwr(8'h04, 32'h04);
		cmd(`FSR_CMD_WREN);
		axi_wr(`FSR_ADDR_OP, 32'h10, OK);
		wait_idle();
		axi_rd(VO, 32'h04, OK);
		fail_req <= 1'b1;
		for (k = 0; k < 3; k++) begin
			cmd(`FSR_CMD_WREN);
			axi_wr(`FSR_ADDR_OP, k == 2 ? 32'hfffff0 : {1'b0, k[0], 30'h10}, OK);
			// a refused op never reaches the array engine, so only real ops wait for done
			for (n = 0; k < 2 && n < 9 && array_result.done !== 1'b1; n++)
				@(posedge sys_clk);
			if (n == 9)
				stall();
			repeat (2) @(posedge sys_clk);
			axi_rd(VO, k == 1 ? 32'h27 : 32'h47, OK);
			cmd(`FSR_CMD_CLRFAIL);
			axi_rd(VO, 32'h06, OK);
			cmd(`FSR_CMD_WRDIS);
		end
	endtask : t_ops
	task automatic t_lock;
		t_regwr(8'h80, 32'h80);
		wp_n <= 1'b0;
		// write enable is no register write, so the latch still sets under the lock
		t_regwr(8'h00, 32'h82);
		wp_n <= 1'b1;
		t_regwr(8'h00, 32'h00);
		axi_wr(`FSR_ADDR_CTRL, 32'h2, OK);
		t_regwr(8'h84, 32'h80);
		// nonvolatile write: protect size stays frozen, lock bit lands in both copies
		cmd(`FSR_CMD_WREN);
		axi_wr(CM, {16'h0, 8'h9c, `FSR_CMD_WRNV}, OK);
		wait_idle();
		axi_rd(`FSR_ADDR_NV, 32'h80, OK);
		axi_rd(VO, 32'h80, OK);
		t_regwr(8'h00, 32'h00);
		cmd(`FSR_CMD_SOFTRST);
		repeat (2) @(posedge sys_clk);
		axi_rd(VO, 32'h80, OK);
		axi_wr(12'h0f0, 32'h0, `FSR_AXI_SLVERR);
		axi_rd(12'h0f0, 32'h0, `FSR_AXI_SLVERR);
	endtask : t_lock
	// ----
	// clock and sequence
	// ----
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		{nrst, fail_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		wp_n = 1'b1;
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		t_wel();
		t_ops();
		t_lock();
		conclude();
	end
endmodule : test_flash_status_register_one
`default_nettype wire

// File: shared/fsr_cfg.svh
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH
// register byte addresses, chosen for this block
`define FSR_ADDR_NV 12'h000
`define FSR_ADDR_VOL 12'h004
`define FSR_ADDR_CMD 12'h008
`define FSR_ADDR_OP 12'h00c
`define FSR_ADDR_CTRL 12'h010
// status register one bit positions
`define FSR_BIT_LOCK 7
`define FSR_BIT_PFAIL 6
`define FSR_BIT_EFAIL 5
`define FSR_BP_HI 4
`define FSR_BP_LO 2
`define FSR_BIT_WEL 1
`define FSR_BIT_BUSY 0
// nonvolatile bits that reach the volatile copy
`define FSR_NV_MASK 8'h9c
`define FSR_NV_RESET 8'h00
// ctrl register bits
`define FSR_CTRL_TB 0
`define FSR_CTRL_PLOCK 1
// command codes written to the command register
`define FSR_CMD_WREN 8'h01
`define FSR_CMD_WREN_VOL 8'h02
`define FSR_CMD_WRDIS 8'h03
`define FSR_CMD_CLRFAIL 8'h04
`define FSR_CMD_SOFTRST 8'h05
`define FSR_CMD_WRNV 8'h06
`define FSR_CMD_WRVOL 8'h07
`define FSR_CMD_PROG 8'h08
`define FSR_CMD_ERASE 8'h09
// operation completion timing
`define FSR_OP_TIME_NS 100
`define FSR_CLK_PERIOD_NS 5
`define FSR_AXI_OKAY 2'b00
`define FSR_AXI_SLVERR 2'b10
`endif

// File: shared/fsr_pkg.sv
package fsr_pkg;
	typedef enum logic [1:0] {
		FSR_OP_NONE,
		FSR_OP_PROG,
		FSR_OP_ERASE,
		FSR_OP_REG
	} fsr_op_t;
	// result of an embedded operation, reported by the array engine
	typedef struct packed {
		logic done;
		logic fail;
	} fsr_done_t;
endpackage : fsr_pkg

// File: src/fsr_status_one.sv
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "fsr_cfg.svh"
// Summary of operation
// - with lock bit set and wp pin low, register-changing commands are ignored
// - wp pin high lets registers change whatever the lock bit says
// - program fail flag set on failed program, stays 0 after success
// - program into a protected region also sets program fail flag
// - program fail flag cleared only by clear-fail command or reset
// - erase fail flag set on failed erase or erase into protected sector
// - erase fail flag cleared only by clear-fail command or reset
// - no return to standby while either fail flag is set
// - protect size code 0 none, 1 one 64th, doubling, 7 whole array
// - program and erase inside the protected region are refused
// - top/bottom select bit places the protected region
// - permanent lock makes both protect size copies read only
// - program, erase, register write run only with write enable latch set
// - write enable and volatile write enable set the latch
// - write disable clears the latch
// - successful program, erase or register write clears the latch
// - latch is 0 after power-up, hardware or software reset
// - busy reads 1 during an embedded operation, 0 in standby
// - fail flags update while busy; after a failed or refused op busy stays set until clear-fail
// - reset copies nonvolatile bits to volatile; nonvolatile writes update both
module fsr_status_one import fsr_pkg::*; #(
	parameter int ADDR_W = 24,
	parameter int OP_CYCLES = (`FSR_OP_TIME_NS + `FSR_CLK_PERIOD_NS - 1) / `FSR_CLK_PERIOD_NS
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic write_protect_n,
	input wire fsr_done_t array_result,
	output logic busy_flag,
	output logic [1:0] op_kind,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	initial begin
		if (ADDR_W < 8 || ADDR_W > 32 || OP_CYCLES < 1)
			$error("fsr_status_one: unsupported parameters");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] nv_r;
	logic [7:0] vol_r;
	logic [1:0] ctrl_r;
	logic [ADDR_W-1:0] op_addr_r;
	logic [7:0] pend_data_r;
	fsr_op_t op_r;
	logic [15:0] op_cnt_r;
	logic pend_nv_r;
	logic soft_rst_r;

	// ----------------------------------------
	// axi-lite write channel
	// ----------------------------------------
	logic [11:0] aw_addr_r;
	logic aw_have_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic w_have_r;
	logic wr_go;
	logic wr_hit;

	// write ready only offered on an edge that really takes the item, so a frozen block loses no write
	assign s_axi_awready = !aw_have_r && !s_axi_bvalid && clk_en;
	assign s_axi_wready = !w_have_r && !s_axi_bvalid && clk_en;
	assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid && clk_en;

	// address and data latch independently, in either order
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 12'h000;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_have_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_go) begin
				w_have_r <= 1'b0;
			end
		end
	end

	// write response, slverr on unmapped address
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FSR_AXI_OKAY;
		end else if (clk_en) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `FSR_AXI_OKAY : `FSR_AXI_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		if (aw_addr_r == `FSR_ADDR_CMD)
			wr_hit = 1'b1;
		else if (aw_addr_r == `FSR_ADDR_OP)
			wr_hit = 1'b1;
		else if (aw_addr_r == `FSR_ADDR_CTRL)
			wr_hit = 1'b1;
		else if (aw_addr_r == `FSR_ADDR_NV || aw_addr_r == `FSR_ADDR_VOL)
			wr_hit = 1'b1;
		else
			wr_hit = 1'b0;
	end

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	logic cmd_wr;
	logic op_wr;
	logic [7:0] cmd;
	logic reg_locked;
	logic busy;
	logic in_region;
	logic op_start;
	logic op_refuse;
	logic [ADDR_W-1:0] op_addr_in;
	logic [2:0] bp;

	assign cmd_wr = wr_go && aw_addr_r == `FSR_ADDR_CMD && w_strb_r[0];
	assign op_wr = wr_go && aw_addr_r == `FSR_ADDR_OP;
	assign cmd = w_data_r[7:0];
	assign op_addr_in = w_data_r[ADDR_W-1:0];
	assign bp = vol_r[`FSR_BP_HI:`FSR_BP_LO];
	// wp high always unlocks; lock bit only bites with wp low
	assign reg_locked = vol_r[`FSR_BIT_LOCK] && !write_protect_n;
	assign busy = vol_r[`FSR_BIT_BUSY];

	// protected region: size doubles per code, 7 covers all; placed top or bottom
	always_comb begin
		logic [ADDR_W-1:0] span;
		logic [ADDR_W:0] full;
		span = '0;
		full = '0;
		full[ADDR_W] = 1'b1;
		if (bp == 3'h7)
			span = '1;
		else if (bp != 3'h0)
			span = ADDR_W'(full >> (7 - 32'(bp)));
		if (bp == 3'h0)
			in_region = 1'b0;
		else if (bp == 3'h7)
			in_region = 1'b1;
		else if (ctrl_r[`FSR_CTRL_TB])
			in_region = op_addr_in < span;
		else
			in_region = op_addr_in >= ADDR_W'(~span + 1'b1);
	end

	// a program or erase only launches when idle and enabled
	assign op_start = op_wr && !busy && vol_r[`FSR_BIT_WEL] && w_data_r[31] == 1'b0;
	assign op_refuse = op_start && in_region;
	assign busy_flag = busy;
	assign op_kind = op_r;

	// ----------------------------------------
	// operation sequencer and status bits
	// ----------------------------------------
	logic op_done;
	logic [7:0] nv_wval;
	logic bp_frozen;

	assign op_done = op_r != FSR_OP_NONE && (op_r == FSR_OP_REG ? op_cnt_r == 16'h0001 : array_result.done);
	assign bp_frozen = ctrl_r[`FSR_CTRL_PLOCK];
	// keep protect bits when permanently locked
	// value byte sits above the command code, as for the volatile write
	assign nv_wval = bp_frozen ? {w_data_r[15:13], nv_r[`FSR_BP_HI:`FSR_BP_LO], w_data_r[9:8]}
		: w_data_r[15:8];

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl_r <= 2'b00;
		end else if (clk_en && wr_go && aw_addr_r == `FSR_ADDR_CTRL && !reg_locked) begin
			ctrl_r <= w_data_r[1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			nv_r <= `FSR_NV_RESET;
		end else if (clk_en && op_done && op_r == FSR_OP_REG && pend_nv_r) begin
			nv_r <= pend_data_r & `FSR_NV_MASK;
		end
	end

	// volatile copy: wel, busy, fail flags and loaded nonvolatile fields
	always_ff @(posedge sys_clk) begin
		if (!nrst || (soft_rst_r && clk_en)) begin
			// reset loads nonvolatile image, wel and flags cleared
			vol_r <= nrst ? (nv_r & `FSR_NV_MASK) : `FSR_NV_RESET;
			op_r <= FSR_OP_NONE;
			op_cnt_r <= 16'h0000;
			op_addr_r <= '0;
			pend_data_r <= 8'h00;
			pend_nv_r <= 1'b0;
		end else if (clk_en) begin
			if (op_r == FSR_OP_REG && op_cnt_r != 16'h0000)
				op_cnt_r <= op_cnt_r - 16'h0001;
			if (op_done) begin
				op_r <= FSR_OP_NONE;
				if (op_r == FSR_OP_PROG)
					vol_r[`FSR_BIT_PFAIL] <= array_result.fail;
				if (op_r == FSR_OP_ERASE)
					vol_r[`FSR_BIT_EFAIL] <= array_result.fail;
				if (op_r == FSR_OP_REG) begin
					// register write lands in the volatile copy, and in nv_r too only for a nonvolatile write; fail flags stay read-only
					vol_r[`FSR_BIT_LOCK] <= pend_data_r[`FSR_BIT_LOCK];
					if (!bp_frozen)
						vol_r[`FSR_BP_HI:`FSR_BP_LO] <= pend_data_r[`FSR_BP_HI:`FSR_BP_LO];
				end
				if (!(op_r != FSR_OP_REG && array_result.fail)) begin
					vol_r[`FSR_BIT_WEL] <= 1'b0;
					vol_r[`FSR_BIT_BUSY] <= 1'b0;
				end
			end else if (op_refuse) begin
				// refused in-region op: flag set, device stays busy until cleared
				if (w_data_r[30])
					vol_r[`FSR_BIT_EFAIL] <= 1'b1;
				else
					vol_r[`FSR_BIT_PFAIL] <= 1'b1;
				vol_r[`FSR_BIT_BUSY] <= 1'b1;
			end else if (op_start) begin
				op_r <= w_data_r[30] ? FSR_OP_ERASE : FSR_OP_PROG;
				op_addr_r <= op_addr_in;
				vol_r[`FSR_BIT_BUSY] <= 1'b1;
			end else if (cmd_wr) begin
				if (cmd == `FSR_CMD_CLRFAIL && op_r == FSR_OP_NONE) begin
					// standby only once flags are clear
					vol_r[`FSR_BIT_PFAIL] <= 1'b0;
					vol_r[`FSR_BIT_EFAIL] <= 1'b0;
					vol_r[`FSR_BIT_BUSY] <= 1'b0;
				end else if (busy) begin
					vol_r <= vol_r;
				end else if (cmd == `FSR_CMD_WREN || cmd == `FSR_CMD_WREN_VOL) begin
					vol_r[`FSR_BIT_WEL] <= 1'b1;
				end else if (cmd == `FSR_CMD_WRDIS) begin
					vol_r[`FSR_BIT_WEL] <= 1'b0;
				end else if ((cmd == `FSR_CMD_WRNV || cmd == `FSR_CMD_WRVOL) && vol_r[`FSR_BIT_WEL]
					&& !reg_locked) begin
					op_r <= FSR_OP_REG;
					op_cnt_r <= 16'(OP_CYCLES);
					pend_nv_r <= cmd == `FSR_CMD_WRNV;
					pend_data_r <= cmd == `FSR_CMD_WRNV ? nv_wval
						: (bp_frozen ? {w_data_r[15:13], vol_r[`FSR_BP_HI:`FSR_BP_LO], 2'b00}
						: {w_data_r[15:10], 2'b00});
					vol_r[`FSR_BIT_BUSY] <= 1'b1;
				end
			end
		end
	end

	// software reset reloads volatile copy one cycle after the command
	always_ff @(posedge sys_clk) begin
		if (!nrst)
			soft_rst_r <= 1'b0;
		else if (clk_en)
			soft_rst_r <= cmd_wr && cmd == `FSR_CMD_SOFTRST && !busy;
	end

	// ----------------------------------------
	// axi-lite read channel
	// ----------------------------------------
	logic [31:0] rd_val;

	always_comb begin
		if (s_axi_araddr == `FSR_ADDR_NV)
			rd_val = {24'h000000, nv_r};
		else if (s_axi_araddr == `FSR_ADDR_VOL)
			rd_val = {24'h000000, vol_r};
		else if (s_axi_araddr == `FSR_ADDR_CTRL)
			rd_val = {30'h0, ctrl_r};
		else if (s_axi_araddr == `FSR_ADDR_OP)
			rd_val = 32'(op_addr_r);
		else
			rd_val = 32'h0000_0000;
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `FSR_AXI_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= (s_axi_araddr == `FSR_ADDR_CMD || s_axi_araddr > `FSR_ADDR_CTRL
					|| s_axi_araddr[1:0] != 2'b00) ? `FSR_AXI_SLVERR : `FSR_AXI_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : fsr_status_one
`default_nettype wire
